// ---- verilog/stage_irq_pkg.sv ----
package stage_irq_pkg;
    localparam int unsigned STAGE_COUNT = 8;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 16;
    localparam logic [9:0] HIGH_EN_ADDR = 10'h006;
    localparam logic [9:0] DONE_EN_ADDR = 10'h007;
    localparam logic [9:0] HIGH_STAT_ADDR = 10'h009;
    localparam logic [9:0] DONE_STAT_ADDR = 10'h00a;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] RDATA_RESET = 16'h0000;
    localparam logic IRQ_N_RESET = 1'b1;
    localparam int unsigned ENABLE_LSB = 0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] high_exceeded;
        logic [7:0] stage_done;
    } stage_event_t;

    typedef struct packed {
        logic [7:0] high_en;
        logic [7:0] done_en;
        logic [7:0] high_stat;
        logic [7:0] done_stat;
        logic [15:0] rdata;
        logic irq_n;
    } irq_state_t;
endpackage

// ---- verilog/stage_interrupt_enable.sv ----
`timescale 1ns/1ps
module stage_interrupt_enable (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire stage_irq_pkg::reg_req_t req_in,
    input wire stage_irq_pkg::stage_event_t event_in,
    output logic [15:0] rdata_out,
    output logic irq_n_out
);
    import stage_irq_pkg::*;

    irq_state_t state_reg;
    irq_state_t state_next;
    logic [7:0] high_pend;
    logic [7:0] done_pend;
    logic high_rd_hit;
    logic done_rd_hit;
    logic high_wr_hit;
    logic done_wr_hit;

    function automatic logic [15:0] widen(input logic [7:0] v);
        return {8'h00, v};
    endfunction

    function automatic logic read_hit(input reg_req_t r, input logic [9:0] a);
        return r.rd && (r.addr == a);
    endfunction

    function automatic logic write_hit(input reg_req_t r, input logic [9:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // a read clears the status, but an event in the read cycle wins so no exceedance is lost
    function automatic logic [7:0] status_update(input logic [7:0] old, input logic [7:0] ev, input logic rd_hit);
        logic [7:0] kept;
        kept = rd_hit ? 8'h00 : old;
        return kept | ev;
    endfunction

    function automatic logic [7:0] enable_update(input logic [7:0] old, input logic [15:0] wdata, input logic wr_hit);
        return wr_hit ? wdata[ENABLE_LSB +: 8] : old;
    endfunction

    assign high_rd_hit = read_hit(req_in, HIGH_STAT_ADDR);
    assign done_rd_hit = read_hit(req_in, DONE_STAT_ADDR);
    assign high_wr_hit = write_hit(req_in, HIGH_EN_ADDR);
    assign done_wr_hit = write_hit(req_in, DONE_EN_ADDR);

    always_comb begin
        state_next = state_reg;
        state_next.high_stat = status_update(state_reg.high_stat, event_in.high_exceeded, high_rd_hit);
        state_next.done_stat = status_update(state_reg.done_stat, event_in.stage_done, done_rd_hit);
        // upper bits are not stored, so a host that ignores the zero-write convention does no harm
        state_next.high_en = enable_update(state_reg.high_en, req_in.wdata, high_wr_hit);
        state_next.done_en = enable_update(state_reg.done_en, req_in.wdata, done_wr_hit);
        state_next.rdata = RDATA_RESET;
        if (req_in.rd) begin
            case (req_in.addr)
                HIGH_EN_ADDR: state_next.rdata = widen(state_reg.high_en);
                DONE_EN_ADDR: state_next.rdata = widen(state_reg.done_en);
                HIGH_STAT_ADDR: state_next.rdata = widen(state_reg.high_stat);
                DONE_STAT_ADDR: state_next.rdata = widen(state_reg.done_stat);
                default: state_next.rdata = 16'h0000;
            endcase
        end
        high_pend = state_next.high_stat & state_next.high_en;
        done_pend = state_next.done_stat & state_next.done_en;
        state_next.irq_n = ~(|high_pend | |done_pend);
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg.high_en <= ENABLE_RESET;
            state_reg.done_en <= ENABLE_RESET;
            state_reg.high_stat <= STATUS_RESET;
            state_reg.done_stat <= STATUS_RESET;
            state_reg.rdata <= RDATA_RESET;
            state_reg.irq_n <= IRQ_N_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_out = state_reg.rdata;
    assign irq_n_out = state_reg.irq_n;

    high_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (|(state_reg.high_stat & state_reg.high_en)) |-> !irq_n_out)
        else $error("enabled high status without interrupt");
    off_quiet_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (state_reg.high_en == 8'h00 && state_reg.done_en == 8'h00) |-> irq_n_out)
        else $error("interrupt with all sources disabled");
    done_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (|(state_reg.done_stat & state_reg.done_en)) |-> !irq_n_out)
        else $error("enabled done status without interrupt");
    done_masked_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (!irq_n_out) |-> |((state_reg.done_stat & state_reg.done_en) | (state_reg.high_stat & state_reg.high_en)))
        else $error("interrupt without enabled pending source");
    reset_zero_a: assert property (@(posedge clk_in)
        $rose(arst_n_in) |-> (state_reg.high_en == 8'h00 && state_reg.done_en == 8'h00))
        else $error("enables not zero after reset");
    read_clear_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (req_in.rd && req_in.addr == HIGH_STAT_ADDR && event_in.high_exceeded == 8'h00)
        |=> (state_reg.high_stat == 8'h00))
        else $error("high status not cleared by read");
    event_set_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (event_in.stage_done != 8'h00) |=> ((state_reg.done_stat & $past(event_in.stage_done)) == $past(event_in.stage_done)))
        else $error("completion event lost");
    enable_write_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (req_in.wr && req_in.addr == HIGH_EN_ADDR) |=> (state_reg.high_en == $past(req_in.wdata[7:0])))
        else $error("high enable write not stored");
    done_write_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        done_wr_hit
        |=> (state_reg.done_en == $past(req_in.wdata[7:0])))
        else $error("completion enable write not stored");
    high_keep_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !high_wr_hit
        |=> $stable(state_reg.high_en))
        else $error("high enable changed without a write");
    done_keep_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !done_wr_hit
        |=> $stable(state_reg.done_en))
        else $error("completion enable changed without a write");
    upper_zero_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (rdata_out[15:8] == 8'h00))
        else $error("unused read bits not zero");

    read_high_en_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        read_hit(req_in, HIGH_EN_ADDR)
        |=> (rdata_out == widen($past(state_reg.high_en))))
        else $error("high enable read back wrong");
    read_done_en_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        read_hit(req_in, DONE_EN_ADDR)
        |=> (rdata_out == widen($past(state_reg.done_en))))
        else $error("completion enable read back wrong");
    read_high_stat_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        high_rd_hit
        |=> (rdata_out == widen($past(state_reg.high_stat))))
        else $error("high status read back wrong");
    read_done_stat_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        done_rd_hit
        |=> (rdata_out == widen($past(state_reg.done_stat))))
        else $error("completion status read back wrong");
    read_idle_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !req_in.rd
        |=> (rdata_out == RDATA_RESET))
        else $error("read data not zero outside a read");

    done_clear_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (done_rd_hit && event_in.stage_done == 8'h00)
        |=> (state_reg.done_stat == 8'h00))
        else $error("completion status not cleared by read");
    high_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        high_rd_hit
        |=> (state_reg.high_stat == $past(event_in.high_exceeded)))
        else $error("still exceeded limit lost by read");
    done_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        done_rd_hit
        |=> (state_reg.done_stat == $past(event_in.stage_done)))
        else $error("completion in read cycle lost");
    high_sticky_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !high_rd_hit
        |=> (state_reg.high_stat == ($past(state_reg.high_stat) | $past(event_in.high_exceeded))))
        else $error("high status changed without read or event");
    done_sticky_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !done_rd_hit
        |=> (state_reg.done_stat == ($past(state_reg.done_stat) | $past(event_in.stage_done))))
        else $error("completion status changed without read or event");
    high_set_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (event_in.high_exceeded != 8'h00)
        |=> ((state_reg.high_stat & $past(event_in.high_exceeded)) == $past(event_in.high_exceeded)))
        else $error("high exceedance lost");

    high_now_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (|(event_in.high_exceeded & state_reg.high_en) && !high_wr_hit)
        |=> !irq_n_out)
        else $error("enabled high exceedance did not raise interrupt");
    done_now_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (|(event_in.stage_done & state_reg.done_en) && !done_wr_hit)
        |=> !irq_n_out)
        else $error("enabled completion did not raise interrupt");
    masked_quiet_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (!high_wr_hit && !done_wr_hit
            && ((state_reg.high_stat | event_in.high_exceeded) & state_reg.high_en) == 8'h00
            && ((state_reg.done_stat | event_in.stage_done) & state_reg.done_en) == 8'h00)
        |=> irq_n_out)
        else $error("masked source raised the interrupt");
    irq_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (!irq_n_out && !high_wr_hit && !done_wr_hit && !high_rd_hit && !done_rd_hit)
        |=> !irq_n_out)
        else $error("pending interrupt dropped without host action");
    irq_release_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $rose(irq_n_out)
        |-> $past(high_rd_hit || done_rd_hit || high_wr_hit || done_wr_hit))
        else $error("interrupt released without host action");
    reset_quiet_a: assert property (@(posedge clk_in)
        $rose(arst_n_in)
        |-> (irq_n_out && rdata_out == RDATA_RESET && state_reg.high_stat == STATUS_RESET
            && state_reg.done_stat == STATUS_RESET))
        else $error("outputs not idle after reset");

    // one copy per stage so a single broken lane is named by its index
    for (genvar i = 0; i < STAGE_COUNT; i++) begin : stage_g
        high_bit_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
            (state_reg.high_en[i] && event_in.high_exceeded[i] && !high_wr_hit)
            |=> (state_reg.high_stat[i] && !irq_n_out))
            else $error("stage high exceedance not latched");
        done_bit_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
            (state_reg.done_en[i] && event_in.stage_done[i] && !done_wr_hit)
            |=> (state_reg.done_stat[i] && !irq_n_out))
            else $error("stage completion not latched");
    end
endmodule

// ---- verification/host_model.sv ----
`timescale 1ns/1ps
module host_model (
    input wire logic clk_in,
    output stage_irq_pkg::reg_req_t req_out,
    input wire logic [15:0] rdata_in
);
    initial req_out = '0;
    task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [15:0] q);
        @(posedge clk_in) #1 req_out <= '{w, ~w, a, {8'h00, d}};
        @(posedge clk_in) #1 req_out <= '{1'b0, 1'b0, ~a, 16'hffff};
        q = rdata_in;
    endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import stage_irq_pkg::*;
    logic clk_in = 1'b0, arst_n_in = 1'b0, irq_n;
    logic [15:0] rdata, v;
    reg_req_t req;
    stage_event_t ev = '0;
    int mismatches = 0, tests_run = 0;
    stage_interrupt_enable dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(req), .event_in(ev),
        .rdata_out(rdata), .irq_n_out(irq_n));
    host_model host_u (.clk_in(clk_in), .req_out(req), .rdata_in(rdata));
    initial forever #12.5 clk_in = ~clk_in;
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        mismatches += int'(s !== e);
    endtask
    task automatic rchk(input logic [9:0] a, input logic [15:0] e);
        host_u.acc(1'b0, a, 8'h00, v);
        chk(v, e);
    endtask
    task automatic pulse(input stage_event_t e, input logic lvl);
        ev <= e;
        @(posedge clk_in) #1 ev <= '0;
        #50 chk({15'h0000, irq_n}, {15'h0000, lvl});
    endtask
    task automatic t_high;
        rchk(HIGH_EN_ADDR, 16'h0000);
        rchk(DONE_EN_ADDR, 16'h0000);
        host_u.acc(1'b1, HIGH_EN_ADDR, 8'h80, v);
        rchk(HIGH_EN_ADDR, 16'h0080);
        pulse('{8'h80, 8'h00}, 1'b0);
        rchk(HIGH_STAT_ADDR, 16'h0080);
        chk({15'h0000, irq_n}, 16'h0001);
        $display("high source test finished");
    endtask
    task automatic t_hold;
        ev <= '{8'h80, 8'h00};
        rchk(HIGH_STAT_ADDR, 16'h0080);
        chk({15'h0000, irq_n}, 16'h0000);
        ev <= '0;
        rchk(HIGH_STAT_ADDR, 16'h0080);
        rchk(HIGH_STAT_ADDR, 16'h0000);
        chk({15'h0000, irq_n}, 16'h0001);
        $display("held limit test finished");
    endtask
    task automatic t_reset;
        pulse('{8'h80, 8'h00}, 1'b0);
        arst_n_in = 1'b0;
        @(posedge clk_in) #1 chk({15'h0000, irq_n}, 16'h0001);
        @(posedge clk_in) #1 arst_n_in = 1'b1;
        rchk(HIGH_EN_ADDR, 16'h0000);
        rchk(DONE_EN_ADDR, 16'h0000);
        rchk(HIGH_STAT_ADDR, 16'h0000);
        $display("reset test finished");
    endtask
    task automatic t_done;
        host_u.acc(1'b1, DONE_EN_ADDR, 8'h01, v);
        rchk(DONE_EN_ADDR, 16'h0001);
        pulse('{8'h00, 8'h01}, 1'b0);
        rchk(DONE_STAT_ADDR, 16'h0001);
        pulse('{8'h7f, 8'hfe}, 1'b1);
        rchk(10'h3ff, 16'h0000);
        $display("completion source test finished");
    endtask
    initial begin
        #63.5 arst_n_in = 1'b1;
        t_high;
        t_hold;
        t_done;
        t_reset;
        give_verdict(0);
    end
    initial #100000 give_verdict(1);
    task automatic give_verdict(input int late);
        mismatches += late;
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
endmodule
